// *** src/vlhp_regs.vh ***
// Constants of the variable-latency host port: strap codes, timing counts.
// Assumes inclusion by src/vlhp_port.v only; definitions only.
// Notes on behaviour
// - Port stretches access by holding not-ready.
// - Bursts repeat strobes under one select.
// - Mode straps latched at reset release.
// - Sixteen address bits, byte lanes from selects.
// - Memory-or-register input routes each access.
// - Wait holds until data valid or accepted.
// - Clock input sources internal bus clock.
// - Endian strap selects little endian.
// - Strap code 100 selects this bus mode.
// - Strap picks wait output polarity.
// - Divider straps divide clock by one to four.
`ifndef VLHP_REGS_VH
`define VLHP_REGS_VH
`define VLHP_MODE_GENERIC2 3'h4
`define VLHP_ENDIAN_LITTLE 1'h0
`define VLHP_SEL_REGS      1'h0
`define VLHP_DIV_W         2
`define VLHP_ARB_WAIT_DEF  4'h2
`endif

// *** src/vlhp_port.v ***
// Variable-latency 16-bit host port with wait handshake and arbitration.
// Assumes host pins are asynchronous to ref_clk_i; memory side is same clock.
`timescale 1ns/1ns
`default_nettype none
`include "vlhp_regs.vh"
module vlhp_port #(
  parameter [3:0] ARB_WAIT = `VLHP_ARB_WAIT_DEF
) (
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  input  wire [2:0]  bus_mode_straps_i,
  input  wire        endian_strap_i,
  input  wire        wait_polarity_strap_i,
  input  wire [1:0]  clock_divide_straps_i,
  input  wire        dev_chip_select_n_i,
  input  wire [15:0] dev_address_inputs_i,
  input  wire        dev_low_byte_select_n_i,
  input  wire        dev_high_byte_select_n_i,
  input  wire        dev_mem_reg_select_i,
  input  wire        dev_read_strobe_n_i,
  input  wire        dev_write_strobe_n_i,
  input  wire        bus_start_input_n_i,
  input  wire        dev_read_write_n_i,
  input  wire [15:0] dev_data_bus_i,
  output reg  [15:0] dev_data_bus_o,
  output reg         dev_data_bus_oe_o,
  output reg         dev_wait_o,
  output reg         bus_clk_en_o,
  output reg         mode_ok_o,
  output reg         little_endian_o,
  output reg         mem_req_o,
  output reg         mem_we_o,
  output reg         mem_sel_buf_o,
  output reg  [15:0] mem_addr_o,
  output reg  [1:0]  mem_be_o,
  output reg  [15:0] mem_wdata_o,
  input  wire        mem_gnt_i,
  input  wire        mem_rvalid_i,
  input  wire [15:0] mem_rdata_i
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARB  = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  // Pin bundle: mem_reg, low_sel_n, data, address, hi_sel_n, wr_n, rd_n, cs_n
  localparam integer SYNC_W   = 38;
  localparam [37:0]  SYNC_RST = 38'h0000000000F;

  // Two-flop synchronisers for host pins
  wire [SYNC_W-1:0] pin_raw;
  wire [SYNC_W-1:0] pin_sync;
  wire [3:0]        ctl_s2_q;
  wire [33:0]       dat_s2_q;

  // Reset-release strap capture
  reg        cfg_done_q;
  reg        wait_pol_q;
  reg [1:0]  div_q;

  // Bus clock divider and access sequencer
  reg [1:0]  div_cnt_q;
  reg [1:0]  state_q;
  reg [3:0]  arb_cnt_q;
  reg        is_read_q;

  // Decoded access request
  wire       cs_act;
  wire       rd_act;
  wire       wr_act;
  wire       strobe;

  function wait_level;
    input busy;
    input pol;
    begin
      wait_level = pol ? busy : ~busy;
    end
  endfunction

  assign pin_raw  = {dev_mem_reg_select_i, dev_low_byte_select_n_i,
                     dev_data_bus_i, dev_address_inputs_i,
                     dev_high_byte_select_n_i, dev_write_strobe_n_i,
                     dev_read_strobe_n_i, dev_chip_select_n_i};
  assign ctl_s2_q = pin_sync[3:0];
  assign dat_s2_q = pin_sync[37:4];

  assign cs_act = ~ctl_s2_q[0];
  assign rd_act = ~ctl_s2_q[1];
  assign wr_act = ~ctl_s2_q[2] & ctl_s2_q[1];
  assign strobe = cs_act & (rd_act | wr_act) & mode_ok_o;

  // Each pin bit passes two flops before any logic reads it
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          s1_q <= SYNC_RST[g];
          s2_q <= SYNC_RST[g];
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
        end
      end
      assign pin_sync[g] = s2_q;
    end
  endgenerate

  // Straps are caught at the first edge after reset release
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_done_q      <= 1'b0;
      wait_pol_q      <= 1'b0;
      div_q           <= 2'h0;
      mode_ok_o       <= 1'b0;
      little_endian_o <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q      <= 1'b1;
      mode_ok_o       <= (bus_mode_straps_i == `VLHP_MODE_GENERIC2);
      little_endian_o <= (endian_strap_i == `VLHP_ENDIAN_LITTLE);
      wait_pol_q      <= wait_polarity_strap_i;
      div_q           <= clock_divide_straps_i;
    end
  end

  // Bus clock enable: divide by strap code plus one
  // Held idle until the divider strap is caught, so the first period is whole
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt_q    <= 2'h0;
      bus_clk_en_o <= 1'b0;
    end else if (!cfg_done_q) begin
      div_cnt_q    <= 2'h0;
      bus_clk_en_o <= 1'b0;
    end else begin
      bus_clk_en_o <= (div_cnt_q == 2'h0);
      div_cnt_q    <= (div_cnt_q >= div_q) ? 2'h0 : div_cnt_q + 2'h1;
    end
  end

  // Read data is driven while a read is selected and in progress
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dev_data_bus_oe_o <= 1'b0;
    end else begin
      dev_data_bus_oe_o <= cs_act & rd_act & (state_q != ST_IDLE);
    end
  end

  // Access sequencer: take request, arbitrate, hold wait, release
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q           <= ST_IDLE;
      arb_cnt_q         <= 4'h0;
      is_read_q         <= 1'b0;
      dev_wait_o        <= 1'b1;
      dev_data_bus_o    <= 16'h0;
      mem_req_o         <= 1'b0;
      mem_we_o          <= 1'b0;
      mem_sel_buf_o     <= 1'b0;
      mem_addr_o        <= 16'h0;
      mem_be_o          <= 2'h0;
      mem_wdata_o       <= 16'h0;
    end else begin
      case (state_q)

        ST_IDLE: begin
          dev_wait_o <= wait_level(1'b0, wait_pol_q);
          if (strobe) begin
            dev_wait_o    <= wait_level(1'b1, wait_pol_q);
            is_read_q     <= rd_act;
            mem_req_o     <= 1'b1;
            mem_we_o      <= ~rd_act;
            mem_sel_buf_o <= (dat_s2_q[33] != `VLHP_SEL_REGS);
            mem_addr_o    <= dat_s2_q[15:0];
            mem_be_o      <= {~ctl_s2_q[3], ~dat_s2_q[32]};
            mem_wdata_o   <= dat_s2_q[31:16];
            arb_cnt_q     <= ARB_WAIT;
            state_q       <= ST_ARB;
          end
        end

        ST_ARB: begin
          dev_wait_o <= wait_level(1'b1, wait_pol_q);
          if (arb_cnt_q != 4'h0)
            arb_cnt_q <= arb_cnt_q - 4'h1;
          if (mem_gnt_i)
            mem_req_o <= 1'b0;
          if (!mem_req_o && (!is_read_q || mem_rvalid_i) && arb_cnt_q == 4'h0) begin
            if (is_read_q)
              dev_data_bus_o <= mem_rdata_i;
            state_q <= ST_DONE;
          end
        end

        ST_DONE: begin
          dev_wait_o <= wait_level(1'b0, wait_pol_q);
          if (!(rd_act | wr_act))
            state_q <= ST_IDLE;
        end

        default: begin
          state_q <= ST_IDLE;
        end

      endcase
    end
  end

endmodule // vlhp_port
`default_nettype wire

// *** bench/vlhp_port_properties.sv ***
// Checker on the host port pins.
// Assumes bind onto vlhp_port.
`timescale 1ns/1ns
`default_nettype none
module vlhp_props (input wire ref_clk_i, sys_rst_i, wait_polarity_strap_i, endian_strap_i,
  input wire mode_ok_o, little_endian_o, dev_chip_select_n_i, dev_read_strobe_n_i, dev_wait_o,
  input wire mem_req_o, bus_clk_en_o, input wire [2:0] bus_mode_straps_i,
  input wire [1:0] clock_divide_straps_i, input wire [15:0] dev_address_inputs_i, mem_addr_o);
  wire b = dev_wait_o == wait_polarity_strap_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_mo; $fell(sys_rst_i) |-> ##[1:2] mode_ok_o == (bus_mode_straps_i == 3'h4);
  endproperty
  a_mo: assert property (p_mo) else $error("mode");
  property p_le; $fell(sys_rst_i) |-> ##[1:2] little_endian_o == !endian_strap_i; endproperty
  a_le: assert property (p_le) else $error("endian");
  property p_rf; !mode_ok_o [*4] |-> !b; endproperty
  a_rf: assert property (p_rf) else $error("refused");
  property p_tk; mode_ok_o && !dev_chip_select_n_i && $fell(dev_read_strobe_n_i)
    |-> ##[1:4] b; endproperty
  a_tk: assert property (p_tk) else $error("late wait");
  property p_rq; $rose(mem_req_o) |-> b; endproperty
  a_rq: assert property (p_rq) else $error("no wait");
  property p_hd; b && mem_req_o |=> b; endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_ad; $rose(mem_req_o) |-> mem_addr_o == dev_address_inputs_i; endproperty
  a_ad: assert property (p_ad) else $error("address");
  property p_dv; bus_clk_en_o && clock_divide_straps_i == 2'h1 |=> !bus_clk_en_o ##1 bus_clk_en_o;
  endproperty
  a_dv: assert property (p_dv) else $error("divider");
endmodule // vlhp_props
bind vlhp_port vlhp_props i_vlhp_props (.*);
`default_nettype wire

// *** bench/vlhp_host.sv ***
// Host model: variable-latency IO master, one word per call.
// Assumes the port clock; wait polarity from the strap.
`timescale 1ns/1ns
`default_nettype none
module vlhp_host #(parameter READ_DELAY_SETTING = 5, parameter PRECHARGE_SETTING = 0) (
  input wire ref_clk_i, dev_wait_o, wait_polarity_strap_i, input wire [15:0] dev_data_bus_i,
  output reg dev_chip_select_n_i = 1'h1, dev_read_strobe_n_i = 1'h1, dev_write_strobe_n_i = 1'h1,
  output reg dev_mem_reg_select_i = 1'h0, output reg [15:0] dev_address_inputs_i = 16'h0,
  output reg [15:0] host_dat_o = 16'h0);
  integer k;
  task xfer(input w, m, input [15:0] a, d, output [15:0] q, input last);
    begin
      @(posedge ref_clk_i) dev_chip_select_n_i <= 1'h0;
      dev_address_inputs_i <= a;
      dev_mem_reg_select_i <= m;
      host_dat_o <= w ? d : ~host_dat_o;
      repeat (2) @(posedge ref_clk_i);
      if (w) dev_write_strobe_n_i <= 1'h0;
      else dev_read_strobe_n_i <= 1'h0;
      repeat (READ_DELAY_SETTING - 1) @(posedge ref_clk_i);
      for (k = 0; k < 3; k = (dev_wait_o !== wait_polarity_strap_i) ? k + 1 : 0)
        @(posedge ref_clk_i);
      @(negedge ref_clk_i) q = dev_data_bus_i;
      @(posedge ref_clk_i) dev_read_strobe_n_i <= 1'h1;
      dev_write_strobe_n_i <= 1'h1;
      host_dat_o <= ~host_dat_o;
      repeat (PRECHARGE_SETTING + 1) @(posedge ref_clk_i);
      if (last) dev_chip_select_n_i <= 1'h1;
    end
  endtask
endmodule // vlhp_host
`default_nettype wire

// *** bench/testbench.sv ***
// Bench: host model drives the port, memory side answered here.
// Assumes the host model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  reg ref_clk_i = 1'h0, sys_rst_i = 1'h1, mem_gnt_i = 1'h0, mem_rvalid_i = 1'h0, c_we;
  reg [2:0] bus_mode_straps_i = 3'h4;
  reg [15:0] mem_rdata_i = 16'h0, q, c_d;
  reg [1:0] c_be;
  reg c_sel;
  wire endian_strap_i = 1'h0, wait_polarity_strap_i = 1'h0, bus_start_input_n_i = 1'h1;
  wire dev_read_write_n_i = 1'h1, dev_chip_select_n_i, dev_read_strobe_n_i, dev_write_strobe_n_i;
  wire [1:0] clock_divide_straps_i = 2'h1, mem_be_o;
  wire dev_mem_reg_select_i, dev_data_bus_oe_o, dev_wait_o, bus_clk_en_o, mode_ok_o, mem_we_o;
  wire little_endian_o, mem_req_o, mem_sel_buf_o;
  wire [15:0] dev_address_inputs_i, dev_data_bus_o, mem_addr_o, mem_wdata_o, host_dat_o;
  wire [15:0] dev_data_bus_i = dev_data_bus_oe_o ? dev_data_bus_o : host_dat_o;
  wire dev_low_byte_select_n_i = dev_chip_select_n_i;
  wire dev_high_byte_select_n_i = dev_chip_select_n_i;
  integer bad_count = 0, num_checks = 0, cyc = 0, nreq = 0, n;
  vlhp_port i_vlhp_port (.*);
  vlhp_host i_vlhp_host (.*);
  initial forever #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    mem_gnt_i <= mem_req_o && !mem_gnt_i;
    mem_rvalid_i <= mem_gnt_i || mem_rvalid_i && !(dev_read_strobe_n_i && dev_write_strobe_n_i);
    mem_rdata_i <= mem_addr_o ^ 16'hA5C3;
    if (mem_req_o && mem_gnt_i) begin
      nreq <= nreq + 1;
      c_we <= mem_we_o;
      c_be <= mem_be_o;
      c_d <= mem_wdata_o;
      c_sel <= mem_sel_buf_o;
    end
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  task chk(input [63:0] s, input [15:0] e, v);
    begin
      num_checks = num_checks + 1;
      if (v !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s expected %h seen %h", s, e, v);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task t_rst(input [2:0] m);
    begin
      @(posedge ref_clk_i) sys_rst_i <= 1'h1;
      bus_mode_straps_i <= m;
      repeat (5) @(posedge ref_clk_i);
      sys_rst_i <= 1'h0;
      repeat (3) @(posedge ref_clk_i);
      chk("mode", m == 3'h4, mode_ok_o);
      chk("endian", 16'h1, little_endian_o);
      $display("t_rst done");
    end
  endtask
  task t_wr;
    begin
      n = nreq;
      i_vlhp_host.xfer(1'h1, 1'h0, 16'h1234, 16'hBEEF, q, 1'h1);
      chk("wnreq", 16'h1, nreq - n);
      chk("wsel", 16'h0, c_sel);
      chk("we", 16'h1, c_we);
      chk("wdata", 16'hBEEF, c_d);
      chk("be", 16'h3, c_be);
      $display("t_wr done");
    end
  endtask
  task t_rd;
    begin
      n = nreq;
      i_vlhp_host.xfer(1'h0, 1'h1, 16'h0042, 16'h0000, q, 1'h0);
      chk("rd0", 16'hA581, q);
      chk("rsel", 16'h1, c_sel);
      i_vlhp_host.xfer(1'h0, 1'h1, 16'hFFFF, 16'h0000, q, 1'h1);
      chk("rd1", 16'h5A3C, q);
      chk("nreq", 16'h2, nreq - n);
      $display("t_rd done");
    end
  endtask
  task t_ref;
    begin
      t_rst(3'h0);
      n = nreq;
      i_vlhp_host.xfer(1'h1, 1'h0, 16'h0010, 16'h5555, q, 1'h1);
      chk("refused", 16'h0, nreq - n);
      t_rst(3'h4);
      $display("t_ref done");
    end
  endtask
  initial begin
    t_rst(3'h4);
    t_wr;
    t_rd;
    t_ref;
    t_wr;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
